// *** hdl/mpag_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Pre-decrement address is pointer minus step plus offset
// - Pre-decrement writes back pointer minus one or two
// - Single word reads the decremented location
// - Double word first address is pointer minus two
// - Second address pairs by parity of first
// - Index-add issues unmodified pointer, then adds index
// - Index-subtract issues unmodified pointer, then subtracts index
// - Compat mode selects aux zero for index-add
// - Compat mode selects aux zero for index-subtract
// - Circular mode adds zero-extended start offset to low pointer
module mpag_top
   import mpag_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   input wire logic REQ_I,
   input wire logic [MODE_W-1:0] MODE_I,
   input wire logic DOUBLE_I,
   input wire logic CIRCULAR_I,
   input wire logic LEGACY_COMPAT_MODE_I,
   input wire logic [PTR_W-1:0] EXTENDED_AUX_POINTER_I,
   input wire logic [IDX_W-1:0] BUFFER_START_OFFSET_I,
   input wire logic [IDX_W-1:0] TEMP_INDEX_REG_I,
   input wire logic [PTR_W-1:0] INDEX_AUX_POINTER_I,
   output logic ADDR_VALID_O,
   output logic [PTR_W-1:0] ADDR_O,
   output logic ADDR_SECOND_O,
   output logic PTR_WE_O,
   output logic [PTR_W-1:0] PTR_NEXT_O,
   output logic BUSY_O
);
   mpag_state_type state_reg, state_next;
   logic [PTR_W-1:0] addr_reg;
   logic [PTR_W-1:0] pair_reg;
   logic valid_reg, second_reg, we_reg;
   logic [PTR_W-1:0] ptr_reg;

   // Operand decoding is shared by the datapath and the checks below
   function automatic logic is_pre_dec(input mpag_mode_type m);
      return m == MPAG_PRE_DEC;
   endfunction

   function automatic logic is_active(input mpag_mode_type m);
      return m != MPAG_NONE;
   endfunction

   wire mpag_mode_type mode = mpag_mode_type'(MODE_I);
   wire logic [PTR_W-1:0] step = DOUBLE_I ? STEP_DOUBLE : STEP_SINGLE;
   wire logic [PTR_W-1:0] base = is_pre_dec(mode) ?
      EXTENDED_AUX_POINTER_I - step : EXTENDED_AUX_POINTER_I;
   wire logic [LOW_W-1:0] offset = CIRCULAR_I ? BUFFER_START_OFFSET_I : '0;
   // Offset acts only on the low half; the high half never carries
   wire logic [LOW_W-1:0] low_sum = base[LOW_W-1:0] + offset;
   wire logic [PTR_W-1:0] first_addr = {base[PTR_W-1:LOW_W], low_sum};
   wire logic [PTR_W-1:0] index_val = LEGACY_COMPAT_MODE_I ?
      INDEX_AUX_POINTER_I : {{HIGH_W{1'b0}}, TEMP_INDEX_REG_I};
   logic [PTR_W-1:0] ptr_new;
   wire logic [PTR_W-1:0] second_addr;
   wire logic take = REQ_I && state_reg == MPAG_IDLE && is_active(mode);

   mpag_pair_addr mpag_pair_addr_i (
      .first_i(first_addr),
      .second_o(second_addr)
   );

   always_comb begin
      case (mode)
         MPAG_PRE_DEC: ptr_new = base;
         MPAG_IDX_ADD: ptr_new = EXTENDED_AUX_POINTER_I + index_val;
         MPAG_IDX_SUB: ptr_new = EXTENDED_AUX_POINTER_I - index_val;
         default: ptr_new = EXTENDED_AUX_POINTER_I;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MPAG_IDLE: if (take && DOUBLE_I) state_next = MPAG_SECOND;
         MPAG_SECOND: state_next = MPAG_IDLE;
         default: state_next = MPAG_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_reg <= MPAG_IDLE;
         addr_reg <= PTR_RESET;
         pair_reg <= PTR_RESET;
         ptr_reg <= PTR_RESET;
         valid_reg <= 1'b0;
         second_reg <= 1'b0;
         we_reg <= 1'b0;
      end else if (CE_I) begin
         state_reg <= state_next;
         valid_reg <= take || state_reg == MPAG_SECOND;
         second_reg <= state_reg == MPAG_SECOND;
         // Write back with every taken request: a single word or the first word of a pair
         we_reg <= take;
         if (take) begin
            addr_reg <= first_addr;
            pair_reg <= second_addr;
            ptr_reg <= ptr_new;
         end else if (state_reg == MPAG_SECOND) begin
            addr_reg <= pair_reg;
         end
      end
   end

   assign ADDR_VALID_O = valid_reg;
   assign ADDR_O = addr_reg;
   assign ADDR_SECOND_O = second_reg;
   assign PTR_WE_O = we_reg;
   assign PTR_NEXT_O = ptr_reg;
   assign BUSY_O = state_reg != MPAG_IDLE;

   // A double access runs in two steps: first word with its write-back, then the pair
   sequence s_first_word;
      ADDR_VALID_O && !ADDR_SECOND_O && BUSY_O && PTR_WE_O;
   endsequence

   sequence s_second_word;
      ADDR_VALID_O && ADDR_SECOND_O && !BUSY_O && !PTR_WE_O;
   endsequence

   // Singles may follow each other every cycle, so only the pair is held to one write
   property p_single_we;
      @(posedge CLK_I) disable iff (RESET_I)
      (s_first_word ##0 CE_I) |=> !PTR_WE_O;
   endproperty
   a_single_we: assert property (p_single_we) else $error("pointer written twice");

   property p_double;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && DOUBLE_I) |=> s_first_word;
   endproperty
   a_double: assert property (p_double) else $error("double access did not start");

   property p_pair;
      @(posedge CLK_I) disable iff (RESET_I)
      (s_first_word ##0 CE_I) |=>
      (s_second_word ##0 (ADDR_O == ($past(ADDR_O) ^ PAIR_STEP)));
   endproperty
   a_pair: assert property (p_pair) else $error("bad second address");

   property p_predec;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && mode == MPAG_PRE_DEC && !CIRCULAR_I) |=>
      (ADDR_O == PTR_NEXT_O && PTR_NEXT_O == $past(EXTENDED_AUX_POINTER_I) - $past(step));
   endproperty
   a_predec: assert property (p_predec) else $error("pre-decrement wrong");

   property p_post;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && mode != MPAG_PRE_DEC && !CIRCULAR_I) |=>
      (ADDR_O == $past(EXTENDED_AUX_POINTER_I));
   endproperty
   a_post: assert property (p_post) else $error("post-modify addr wrong");

   // The index source is picked again here from the pins, apart from the datapath mux
   property p_add;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && mode == MPAG_IDX_ADD) |=>
      PTR_NEXT_O == $past(EXTENDED_AUX_POINTER_I) + ($past(LEGACY_COMPAT_MODE_I) ?
      $past(INDEX_AUX_POINTER_I) : PTR_W'($past(TEMP_INDEX_REG_I)));
   endproperty
   a_add: assert property (p_add) else $error("index add wrong");

   property p_sub;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && mode == MPAG_IDX_SUB) |=>
      PTR_NEXT_O == $past(EXTENDED_AUX_POINTER_I) - ($past(LEGACY_COMPAT_MODE_I) ?
      $past(INDEX_AUX_POINTER_I) : PTR_W'($past(TEMP_INDEX_REG_I)));
   endproperty
   a_sub: assert property (p_sub) else $error("index subtract wrong");

   property p_circ;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && CIRCULAR_I && mode != MPAG_PRE_DEC) |=>
      ADDR_O[LOW_W-1:0] == LOW_W'($past(EXTENDED_AUX_POINTER_I[LOW_W-1:0]) +
      $past(BUFFER_START_OFFSET_I));
   endproperty
   a_circ: assert property (p_circ) else $error("circular offset wrong");

   property p_step;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && mode == MPAG_PRE_DEC) |=>
      ($past(EXTENDED_AUX_POINTER_I) - PTR_NEXT_O) ==
      ($past(DOUBLE_I) ? STEP_DOUBLE : STEP_SINGLE);
   endproperty
   a_step: assert property (p_step) else $error("pre-decrement step wrong");

   property p_pre_single;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && is_pre_dec(mode) && !DOUBLE_I && !CIRCULAR_I) |=>
      ADDR_O == $past(EXTENDED_AUX_POINTER_I) - STEP_SINGLE;
   endproperty
   a_pre_single: assert property (p_pre_single) else $error("single pre-dec wrong");

   property p_pre_double;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && is_pre_dec(mode) && DOUBLE_I && !CIRCULAR_I) |=>
      ADDR_O == $past(EXTENDED_AUX_POINTER_I) - STEP_DOUBLE;
   endproperty
   a_pre_double: assert property (p_pre_double) else $error("double pre-dec wrong");

   property p_single_free;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && CE_I && !DOUBLE_I) |=> PTR_WE_O && !BUSY_O && !ADDR_SECOND_O;
   endproperty
   a_single_free: assert property (p_single_free) else $error("single entered pair");

   // A low enable must hold every output, or the core would see a phantom access
   property p_freeze;
      @(posedge CLK_I) disable iff (RESET_I)
      !CE_I |=> $stable(ADDR_VALID_O) && $stable(ADDR_O) && $stable(PTR_WE_O) &&
      $stable(PTR_NEXT_O) && $stable(BUSY_O) && $stable(ADDR_SECOND_O);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_none;
      @(posedge CLK_I) disable iff (RESET_I)
      (REQ_I && !is_active(mode) && !BUSY_O && CE_I) |=> !ADDR_VALID_O && !PTR_WE_O;
   endproperty
   a_none: assert property (p_none) else $error("request without operand taken");

   property p_reset;
      @(posedge CLK_I)
      RESET_I |=> !ADDR_VALID_O && !PTR_WE_O && !BUSY_O && ADDR_O == PTR_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// *** hdl/mpag_pkg.sv ***
package mpag_pkg;
   localparam int PTR_W = 23;
   localparam int LOW_W = 16;
   localparam int HIGH_W = PTR_W - LOW_W;
   localparam int IDX_W = 16;
   localparam logic [PTR_W-1:0] STEP_SINGLE = 23'h000001;
   localparam logic [PTR_W-1:0] STEP_DOUBLE = 23'h000002;
   localparam logic [PTR_W-1:0] PAIR_STEP = 23'h000001;
   localparam logic [PTR_W-1:0] PTR_RESET = 23'h000000;
   localparam int MODE_W = 2;
   typedef enum logic [MODE_W-1:0] {
      MPAG_PRE_DEC = 2'b00,
      MPAG_IDX_ADD = 2'b01,
      MPAG_IDX_SUB = 2'b10,
      MPAG_NONE = 2'b11
   } mpag_mode_type;
   typedef enum logic [1:0] {
      MPAG_IDLE = 2'b00,
      MPAG_SECOND = 2'b01
   } mpag_state_type;
endpackage

// *** hdl/mpag_pair_addr.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpag_pair_addr
   import mpag_pkg::*;
(
   input wire logic [PTR_W-1:0] first_i,
   output logic [PTR_W-1:0] second_o
);
   // Even first word pairs upward, odd pairs downward
   assign second_o = first_i[0] ? first_i - PAIR_STEP : first_i + PAIR_STEP;
endmodule
`default_nettype wire

// *** sim/mpag_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpag_top_test;
   import mpag_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic req = 1'b0;
   logic dbl = 1'b0;
   logic circ = 1'b0;
   logic compat = 1'b0;
   logic [MODE_W-1:0] mode = 2'h3;
   logic [PTR_W-1:0] ptr = 23'h000000;
   logic [PTR_W-1:0] xidx = 23'h000000;
   logic [IDX_W-1:0] off = 16'h0000;
   logic [IDX_W-1:0] tidx = 16'h0000;
   logic av, sec, we, busy;
   logic [PTR_W-1:0] addr, pnext, ea, en;
   integer seed = 32'h856c;
   integer err_total = 0;
   integer checked = 0;
   integer i;
   mpag_top mpag_top_i (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .REQ_I(req), .MODE_I(mode),
      .DOUBLE_I(dbl), .CIRCULAR_I(circ), .LEGACY_COMPAT_MODE_I(compat),
      .EXTENDED_AUX_POINTER_I(ptr), .BUFFER_START_OFFSET_I(off), .TEMP_INDEX_REG_I(tidx),
      .INDEX_AUX_POINTER_I(xidx), .ADDR_VALID_O(av), .ADDR_O(addr), .ADDR_SECOND_O(sec),
      .PTR_WE_O(we), .PTR_NEXT_O(pnext), .BUSY_O(busy));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [PTR_W-1:0] seen, input logic [PTR_W-1:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [PTR_W-1:0] with_off(input logic [PTR_W-1:0] p);
      with_off = p;
      if (circ) with_off[LOW_W-1:0] = p[LOW_W-1:0] + off;
   endfunction
   task automatic run_op(input logic [MODE_W-1:0] m, input logic d, input logic fix,
      input logic stall);
      logic [PTR_W-1:0] st, ix;
      mode = m;
      dbl = d;
      if (!fix) ptr = PTR_W'($random(seed));
      xidx = PTR_W'($random(seed));
      off = IDX_W'($random(seed));
      tidx = IDX_W'($random(seed));
      circ = fix ? 1'b0 : 1'($random(seed));
      compat = 1'($random(seed));
      // Keep low offset sums clear of the 16-bit wrap, which the design leaves open
      if (circ) ptr[15:14] = 2'b01;
      if (circ) off[15:14] = 2'b00;
      req = 1'b1;
      st = d ? STEP_DOUBLE : STEP_SINGLE;
      ix = compat ? xidx : PTR_W'(tidx);
      ea = (m == MPAG_PRE_DEC) ? with_off(ptr - st) : with_off(ptr);
      en = (m == MPAG_PRE_DEC) ? ptr - st : ((m == MPAG_IDX_ADD) ? ptr + ix : ptr - ix);
      @(negedge clk);
      check(av, 1'b1);
      check(sec, 1'b0);
      check(addr, ea);
      check(we, 1'b1);
      check(pnext, en);
      check(busy, d);
      // A low enable parks everything after the first word, whether or not a second word is pending
      if (stall) begin
         ce = 1'b0;
         @(negedge clk);
         check(av, 1'b1);
         check(we, 1'b1);
         check(addr, ea);
         check(busy, d);
         ce = 1'b1;
      end
      if (d) begin
         @(negedge clk);
         check(av, 1'b1);
         check(sec, 1'b1);
         check(addr, {ea[PTR_W-1:1], ~ea[0]});
         check(we, 1'b0);
         check(busy, 1'b0);
      end
      req = 1'b0;
      @(negedge clk);
      check(av, 1'b0);
      check(we, 1'b0);
      $display("op mode %0d double %0d done", m, d);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check(av, 1'b0);
      check(busy, 1'b0);
      $display("reset check done");
      // Pointer near zero: borrow across the full width, even and odd pair cases
      ptr = 23'h000001;
      run_op(MPAG_PRE_DEC, 1'b0, 1'b1, 1'b0);
      ptr = 23'h000000;
      run_op(MPAG_PRE_DEC, 1'b1, 1'b1, 1'b0);
      ptr = 23'h000003;
      run_op(MPAG_PRE_DEC, 1'b1, 1'b1, 1'b1);
      // Singles may be taken every cycle; the caller writes each update back
      mode = MPAG_IDX_ADD;
      dbl = 1'b0;
      compat = 1'b0;
      tidx = 16'h0003;
      ptr = 23'h000100;
      req = 1'b1;
      @(negedge clk);
      check(addr, 23'h000100);
      check(we, 1'b1);
      check(pnext, 23'h000103);
      ptr = 23'h000103;
      @(negedge clk);
      check(addr, 23'h000103);
      check(we, 1'b1);
      check(pnext, 23'h000106);
      req = 1'b0;
      @(negedge clk);
      check(we, 1'b0);
      $display("back-to-back singles done");
      // No operand selected: request must be ignored
      mode = MPAG_NONE;
      req = 1'b1;
      @(negedge clk);
      check(av, 1'b0);
      check(we, 1'b0);
      req = 1'b0;
      @(negedge clk);
      $display("no-operand request done");
      for (i = 0; i < 80; i = i + 1) begin
         run_op(MODE_W'($unsigned($random(seed)) % 3), 1'($random(seed)), 1'b0,
            1'($random(seed)));
      end
      summarize();
   end
   initial begin
      #20000;
      err_total = err_total + 1;
      summarize();
   end
endmodule
`default_nettype wire
